// ---- hw/switch_link_pkg.sv ----
// constants for the per-link control and status registers of the switch
// Functional notes
// - source kind field reports driver type
// - destination link number reported while in use
// - switch links hold four-bit direction field
// - two-bit network field, reset zero
// - discard bit while current packet junk
// - destination side claimed bit
// - source side in use bit
// - processor links same fields, no direction
// - enable bit enables link, selects pin mux
// - width bit: two or five wires
// - error flag on overflow or bad token
// - credit granted to remote end bit
// - credit held from remote end bit
// - greeting write clears credit, sends greeting
// - receiver reset write restarts token framing
// - intra-token symbol gap is value plus one
// - inter-token gap is value plus one
// - static forwarding enable bypasses routing
// - static destination processor select bit
// - static destination channel end field
// - static registers map to links C,D,A,B,G,H,E,F
package switch_link_pkg;
	localparam int num_links = 8;
	localparam int addr_width = 8;

	localparam logic [7:0] switch_link_base = 8'h20;
	localparam logic [7:0] proc_link_base = 8'h40;
	localparam logic [7:0] ext_link_base = 8'h80;
	localparam logic [7:0] static_fwd_base = 8'ha0;

	// status and network fields
	localparam int kind_lsb = 24;
	localparam int dest_lsb = 16;
	localparam int dir_lsb = 8;
	localparam int net_lsb = 4;
	localparam int junk_bit = 2;
	localparam int dst_busy_bit = 1;
	localparam int src_busy_bit = 0;

	// external link fields
	localparam int enable_bit = 31;
	localparam int wide_bit = 30;
	localparam int rx_error_bit = 27;
	localparam int rx_credit_bit = 26;
	localparam int tx_credit_bit = 25;
	localparam int greeting_bit = 24;
	localparam int rx_restart_bit = 23;
	localparam int intra_lsb = 11;
	localparam int inter_lsb = 0;
	localparam int gap_width = 11;

	// static forwarding fields
	localparam int static_en_bit = 31;
	localparam int static_proc_bit = 8;
	localparam int static_chan_lsb = 0;

	localparam logic [3:0] dir_reset = 4'h0;
	localparam logic [1:0] net_reset = 2'h0;
	localparam logic [10:0] gap_reset = 11'h000;
	localparam logic [4:0] chan_reset = 5'h00;

	// external link index (a=0..h=7) served by each static register
	localparam logic [2:0] static_link_map [num_links] = '{
		3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5
	};
endpackage : switch_link_pkg

// ---- hw/switch_link_control_status.sv ----
// per-link control and status registers, token pacing and static forwarding
`timescale 1ns/100ps
module switch_link_control_status (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [15:0] sw_src_kind,
	input wire logic [63:0] sw_dest_link,
	input wire logic [7:0] sw_junk,
	input wire logic [7:0] sw_dest_side_busy,
	input wire logic [7:0] sw_source_side_busy,
	output logic [31:0] sw_direction,
	output logic [15:0] sw_network,
	input wire logic [15:0] pl_src_kind,
	input wire logic [63:0] pl_dest_link,
	input wire logic [7:0] pl_junk,
	input wire logic [7:0] pl_dest_side_busy,
	input wire logic [7:0] pl_source_side_busy,
	output logic [15:0] pl_network,
	output logic [7:0] link_enable,
	output logic [7:0] link_wide,
	input wire logic [7:0] rx_overflow,
	input wire logic [7:0] rx_bad_token,
	input wire logic [7:0] rx_credit_issued,
	input wire logic [7:0] tx_credit_received,
	output logic [7:0] greeting_token,
	output logic [7:0] rx_restart,
	input wire logic [7:0] tx_symbol,
	input wire logic [7:0] tx_token_last,
	output logic [7:0] tx_ready,
	output logic [7:0] static_forward_enable,
	output logic [7:0] static_dest_processor,
	output logic [39:0] static_dest_channel_end
);
	logic [3:0] direction [switch_link_pkg::num_links];
	logic [1:0] sw_net [switch_link_pkg::num_links];
	logic [1:0] pl_net [switch_link_pkg::num_links];
	logic [7:0] enable;
	logic [7:0] wide;
	logic [7:0] rx_error;
	logic [7:0] rx_credit;
	logic [7:0] tx_credit;
	logic [10:0] intra_gap [switch_link_pkg::num_links];
	logic [10:0] inter_gap [switch_link_pkg::num_links];
	logic [11:0] gap_count [switch_link_pkg::num_links];
	logic [7:0] fwd_en;
	logic [7:0] fwd_proc;
	logic [4:0] fwd_chan [switch_link_pkg::num_links];
	logic [31:0] next_rdata;

	genvar i;
	generate
		for (i = 0; i < switch_link_pkg::num_links; i++) begin : g_link
			logic sel_sw;
			logic sel_pl;
			logic sel_ext;
			logic sel_fwd;
			// constant per link so each output bit has one driver
			localparam int fwd_link = int'(switch_link_pkg::static_link_map[i]);

			assign sel_sw = wr && (addr == 8'(switch_link_pkg::switch_link_base + i));
			assign sel_pl = wr && (addr == 8'(switch_link_pkg::proc_link_base + i));
			assign sel_ext = wr && (addr == 8'(switch_link_pkg::ext_link_base + i));
			assign sel_fwd = wr && (addr == 8'(switch_link_pkg::static_fwd_base + i));

			// switch side direction and network
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					direction[i] <= switch_link_pkg::dir_reset;
					sw_net[i] <= switch_link_pkg::net_reset;
				end else if (sel_sw) begin
					direction[i] <= wdata[switch_link_pkg::dir_lsb +: 4];
					sw_net[i] <= wdata[switch_link_pkg::net_lsb +: 2];
				end
			end

			// processor side carries a network only
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pl_net[i] <= switch_link_pkg::net_reset;
				end else if (sel_pl) begin
					pl_net[i] <= wdata[switch_link_pkg::net_lsb +: 2];
				end
			end

			// external link configuration
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					enable[i] <= 1'b0;
					wide[i] <= 1'b0;
					intra_gap[i] <= switch_link_pkg::gap_reset;
					inter_gap[i] <= switch_link_pkg::gap_reset;
				end else if (sel_ext) begin
					enable[i] <= wdata[switch_link_pkg::enable_bit];
					wide[i] <= wdata[switch_link_pkg::wide_bit];
					intra_gap[i] <= wdata[switch_link_pkg::intra_lsb +: 11];
					inter_gap[i] <= wdata[switch_link_pkg::inter_lsb +: 11];
				end
			end

			// one-cycle command strobes from the write-only bits
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					greeting_token[i] <= 1'b0;
					rx_restart[i] <= 1'b0;
				end else begin
					greeting_token[i] <= sel_ext && wdata[switch_link_pkg::greeting_bit];
					rx_restart[i] <= sel_ext && wdata[switch_link_pkg::rx_restart_bit];
				end
			end

			// sticky error, cleared by receiver reset; a new error wins
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					rx_error[i] <= 1'b0;
				end else if (rx_overflow[i] || rx_bad_token[i]) begin
					rx_error[i] <= 1'b1;
				end else if (sel_ext && wdata[switch_link_pkg::rx_restart_bit]) begin
					rx_error[i] <= 1'b0;
				end
			end

			// credit granted to the far end; a restarted receiver owes none
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					rx_credit[i] <= 1'b0;
				end else if (rx_credit_issued[i]) begin
					rx_credit[i] <= 1'b1;
				end else if (sel_ext && wdata[switch_link_pkg::rx_restart_bit]) begin
					rx_credit[i] <= 1'b0;
				end
			end

			// credit held; far end must answer the greeting to refill it
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					tx_credit[i] <= 1'b0;
				end else if (tx_credit_received[i]) begin
					tx_credit[i] <= 1'b1;
				end else if (sel_ext && wdata[switch_link_pkg::greeting_bit]) begin
					tx_credit[i] <= 1'b0;
				end
			end

			// idle gap after each symbol: value plus one cycles
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					gap_count[i] <= 12'h000;
				end else if (tx_symbol[i] && tx_token_last[i]) begin
					gap_count[i] <= {1'b0, inter_gap[i]} + 12'h001;
				end else if (tx_symbol[i]) begin
					gap_count[i] <= {1'b0, intra_gap[i]} + 12'h001;
				end else if (gap_count[i] != 12'h000) begin
					gap_count[i] <= gap_count[i] - 12'h001;
				end
			end

			// a disabled link never offers a slot
			assign tx_ready[i] = enable[i] && tx_credit[i] && (gap_count[i] == 12'h000);

			// static forwarding; register order differs from link order
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					fwd_en[i] <= 1'b0;
					fwd_proc[i] <= 1'b0;
					fwd_chan[i] <= switch_link_pkg::chan_reset;
				end else if (sel_fwd) begin
					fwd_en[i] <= wdata[switch_link_pkg::static_en_bit];
					fwd_proc[i] <= wdata[switch_link_pkg::static_proc_bit];
					fwd_chan[i] <= wdata[switch_link_pkg::static_chan_lsb +: 5];
				end
			end

			assign static_forward_enable[fwd_link] = fwd_en[i];
			assign static_dest_processor[fwd_link] = fwd_proc[i];
			assign static_dest_channel_end[fwd_link * 5 +: 5] = fwd_chan[i];

			assign sw_direction[i * 4 +: 4] = direction[i];
			assign sw_network[i * 2 +: 2] = sw_net[i];
			assign pl_network[i * 2 +: 2] = pl_net[i];
		end
	endgenerate

	assign link_enable = enable;
	assign link_wide = wide;

	// read mux; unlisted bits and addresses read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		for (int k = 0; k < switch_link_pkg::num_links; k++) begin
			if (addr == 8'(switch_link_pkg::switch_link_base + k)) begin
				next_rdata[switch_link_pkg::kind_lsb +: 2] = sw_src_kind[k * 2 +: 2];
				next_rdata[switch_link_pkg::dest_lsb +: 8] = sw_dest_link[k * 8 +: 8];
				next_rdata[switch_link_pkg::dir_lsb +: 4] = direction[k];
				next_rdata[switch_link_pkg::net_lsb +: 2] = sw_net[k];
				next_rdata[switch_link_pkg::junk_bit] = sw_junk[k];
				next_rdata[switch_link_pkg::dst_busy_bit] = sw_dest_side_busy[k];
				next_rdata[switch_link_pkg::src_busy_bit] = sw_source_side_busy[k];
			end
			if (addr == 8'(switch_link_pkg::proc_link_base + k)) begin
				next_rdata[switch_link_pkg::kind_lsb +: 2] = pl_src_kind[k * 2 +: 2];
				next_rdata[switch_link_pkg::dest_lsb +: 8] = pl_dest_link[k * 8 +: 8];
				next_rdata[switch_link_pkg::net_lsb +: 2] = pl_net[k];
				next_rdata[switch_link_pkg::junk_bit] = pl_junk[k];
				next_rdata[switch_link_pkg::dst_busy_bit] = pl_dest_side_busy[k];
				next_rdata[switch_link_pkg::src_busy_bit] = pl_source_side_busy[k];
			end
			if (addr == 8'(switch_link_pkg::ext_link_base + k)) begin
				next_rdata[switch_link_pkg::enable_bit] = enable[k];
				next_rdata[switch_link_pkg::wide_bit] = wide[k];
				next_rdata[switch_link_pkg::rx_error_bit] = rx_error[k];
				next_rdata[switch_link_pkg::rx_credit_bit] = rx_credit[k];
				next_rdata[switch_link_pkg::tx_credit_bit] = tx_credit[k];
				next_rdata[switch_link_pkg::intra_lsb +: 11] = intra_gap[k];
				next_rdata[switch_link_pkg::inter_lsb +: 11] = inter_gap[k];
			end
			if (addr == 8'(switch_link_pkg::static_fwd_base + k)) begin
				next_rdata[switch_link_pkg::static_en_bit] = fwd_en[k];
				next_rdata[switch_link_pkg::static_proc_bit] = fwd_proc[k];
				next_rdata[switch_link_pkg::static_chan_lsb +: 5] = fwd_chan[k];
			end
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule : switch_link_control_status

// ---- test/remote_node_model.sv ----
// far-end node model: returns credit for each greeting
`timescale 1ns/100ps
module remote_node_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [7:0] greeting_token,
	output logic [7:0] tx_credit_received
);
	logic [47:0] pending;
	// slow answer mimics a far end still busy with its own start-up
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 48'h0;
		end else begin
			pending <= {pending[39:0], greeting_token};
		end
	end
	assign tx_credit_received = slow ? pending[47:40] : pending[7:0];
endmodule : remote_node_model

// ---- test/switch_link_control_status_asserts.sv ----
// assertions on register side effects and transmit pacing, link 0 and static register 0 (link 2)
`timescale 1ns/100ps
module switch_link_control_status_asserts (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [31:0] sw_direction,
	input wire logic [7:0] link_enable,
	input wire logic [7:0] link_wide,
	input wire logic [7:0] tx_credit_received,
	input wire logic [7:0] greeting_token,
	input wire logic [7:0] rx_restart,
	input wire logic [7:0] tx_symbol,
	input wire logic [7:0] tx_ready,
	input wire logic [7:0] static_forward_enable
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence ext_wr;
		wr && addr == 8'h80;
	endsequence
	sequence greet_wr;
		ext_wr ##0 wdata[24];
	endsequence
	a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
		else $error("rdata not zero");
	a_greet_pulse: assert property (greet_wr |=> greeting_token[0] ##1 !greeting_token[0])
		else $error("greeting pulse wrong");
	a_greet_cause: assert property (greeting_token[0] |-> $past(wr && addr == 8'h80 && wdata[24]))
		else $error("greeting without write");
	a_restart_pulse: assert property (ext_wr ##0 wdata[23] |=> rx_restart[0])
		else $error("no receiver restart");
	a_credit_clear: assert property (greet_wr ##0 !tx_credit_received[0] |=> !tx_ready[0])
		else $error("credit kept after greeting");
	a_gap_min: assert property (tx_symbol[0] |=> !tx_ready[0])
		else $error("no idle after symbol");
	a_enable_gate: assert property (!link_enable[0] |-> !tx_ready[0])
		else $error("ready while disabled");
	a_width_write: assert property (ext_wr |=> link_wide[0] == $past(wdata[30]))
		else $error("width not taken");
	a_dir_write: assert property (wr && addr == 8'h20 |=> sw_direction[3:0] == $past(wdata[11:8]))
		else $error("direction not taken");
	a_static_map: assert property (wr && addr == 8'ha0 |=> static_forward_enable[2] == $past(wdata[31]))
		else $error("static map wrong");
endmodule : switch_link_control_status_asserts

// ---- test/tb_switch_link_control_status.sv ----
// self-checking bench for the link control and status block
`timescale 1ns/100ps
module tb_switch_link_control_status;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic slow = 1'b0;
	logic rd_q = 1'b0;
	logic [103:0] sws = '0, pls = '0;
	wire [15:0] sw_src_kind, pl_src_kind;
	wire [63:0] sw_dest_link, pl_dest_link;
	wire [7:0] sw_junk, sw_dest_side_busy, sw_source_side_busy;
	wire [7:0] pl_junk, pl_dest_side_busy, pl_source_side_busy;
	logic [7:0] rx_overflow = 8'h0, rx_bad_token = 8'h0, rx_credit_issued = 8'h0;
	logic [7:0] tx_symbol = 8'h0, tx_token_last = 8'h0, tx_credit_received, tx_ready;
	logic [7:0] link_enable, link_wide, greeting_token, rx_restart;
	logic [7:0] static_forward_enable, static_dest_processor;
	logic [15:0] sw_network, pl_network;
	logic [31:0] rdata, sw_direction, d;
	logic [39:0] static_dest_channel_end;
	logic [31:0] expq [$];
	logic [2:0] lk [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};
	int mismatches = 0;
	int comparisons = 0;
	int seed = 97737;
	assign {sw_src_kind, sw_dest_link, sw_junk, sw_dest_side_busy, sw_source_side_busy} = sws;
	assign {pl_src_kind, pl_dest_link, pl_junk, pl_dest_side_busy, pl_source_side_busy} = pls;
	switch_link_control_status switch_link_control_status_i (.*);
	remote_node_model remote_node_model_i (.*);
	initial forever #5 clock = ~clock;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	task automatic wr32(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clock);
	endtask : wr32
	task automatic rd32(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		expq.push_back(e);
		@(posedge clock);
	endtask : rd32
	task automatic idle;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clock);
	endtask : idle
	// counts cycles with tx_ready low, sampled mid-cycle to avoid edge races
	task automatic wait_ready(output int c);
		c = 0;
		@(negedge clock);
		while (tx_ready[0] !== 1'b1 && c < 50) begin
			c++;
			@(negedge clock);
		end
		@(posedge clock);
	endtask : wait_ready
	task automatic gap(input logic last, input int n);
		int c;
		tx_symbol[0] <= 1'b1;
		tx_token_last[0] <= last;
		idle;
		tx_symbol[0] <= 1'b0;
		wait_ready(c);
		check(c, n);
	endtask : gap
	function automatic logic [31:0] st(input logic [103:0] s, input int k, input logic [5:0] dn);
		return {6'h0, s[88+2*k+:2], s[24+8*k+:8], 4'h0, dn[5:2], 2'h0, dn[1:0], 1'b0,
			s[16+k], s[8+k], s[k]};
	endfunction : st
	always @(posedge clock) rd_q <= rd;
	always @(negedge clock) begin
		if (rd_q) check(rdata, expq.pop_front());
	end
	initial begin
		#100000;
		mismatches++;
		complete_run;
	end
	initial begin
		int c;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		sws <= 104'({$random(seed), $random(seed), $random(seed), $random(seed)});
		pls <= 104'({$random(seed), $random(seed), $random(seed), $random(seed)});
		@(posedge clock);
		for (int k = 0; k < 8; k++) begin
			d = $random(seed);
			rd32(8'h20 + 8'(k), st(sws, k, 6'h00));
			rd32(8'h40 + 8'(k), st(pls, k, 6'h00));
			wr32(8'h20 + 8'(k), d);
			wr32(8'h40 + 8'(k), d);
			rd32(8'h20 + 8'(k), st(sws, k, {d[11:8], d[5:4]}));
			rd32(8'h40 + 8'(k), st(pls, k, {4'h0, d[5:4]}));
		end
		idle;
		check(pl_network[15:14], d[5:4]);
		check(sw_network[15:14], d[5:4]);
		check(sw_direction[31:28], d[11:8]);
		wr32(8'h88, 32'hffffffff);
		rd32(8'h88, 32'h0);
		rd32(8'h80, 32'h0);
		wr32(8'h80, 32'hc000_1805);
		rd32(8'h80, 32'hc000_1805);
		idle;
		check({link_enable[0], link_wide[0]}, 2'h3);
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			wr32(8'h80, 32'hc100_1805);
			idle;
			wait_ready(c);
			rd32(8'h80, 32'hc200_1805);
		end
		for (int e = 0; e < 2; e++) begin
			rx_credit_issued[0] <= 1'b1;
			rx_overflow[0] <= (e == 0);
			rx_bad_token[0] <= (e == 1);
			idle;
			{rx_overflow[0], rx_bad_token[0], rx_credit_issued[0]} <= 3'h0;
			rd32(8'h80, 32'hce00_1805);
			wr32(8'h80, 32'hc080_1805);
			rd32(8'h80, 32'hc200_1805);
		end
		gap(1'b0, 4);
		gap(1'b1, 6);
		wr32(8'h80, 32'hc000_0000);
		gap(1'b1, 1);
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			wr32(8'ha0 + 8'(i), d);
			rd32(8'ha0 + 8'(i), d & 32'h8000_011f);
			check({static_forward_enable[lk[i]], static_dest_processor[lk[i]],
				static_dest_channel_end[5*lk[i]+:5]}, {d[31], d[8], d[4:0]});
		end
		wr32(8'h80, 32'h0);
		repeat (3) idle;
		complete_run;
	end
endmodule : tb_switch_link_control_status
bind switch_link_control_status
	switch_link_control_status_asserts switch_link_control_status_asserts_i (.*);
